// file: verilog/fault_seq_cfg.svh
/*
 * Constants for the flyback fault sequencer: clock rate, documented delays,
 * and bit positions inside the synchronised input vectors.
 * Assumes a single 100 MHz clock; included by bare name.
 */
`ifndef FAULT_SEQ_CFG_SVH
`define FAULT_SEQ_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and delays
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS         10
`define AUTOREC_TIME_MS       1200
`define BROWNOUT_TIME_MS      54
`define LINE_REMOVAL_TIME_MS  100
`define UPSLOPE_TIME_MS       14
`define DOWNSLOPE_TIME_MS     1
`define BLANKING_TIME_US      30
`define NS_PER_MS             1000000
`define NS_PER_US             1000
`define SYNC_STAGES           2

// ----------------------------------------------------------------------------
// Positions in the plain input vector
// ----------------------------------------------------------------------------
`define IN_SUPPLY_ON          0
`define IN_SUPPLY_OFF         1
`define IN_SUPPLY_RESET       2
`define IN_LINE_START         3
`define IN_LINE_STOP          4
`define IN_LINE_DISCH_END     5
`define IN_SLOPE_UP           6
`define IN_SLOPE_DOWN         7
`define IN_ABNORMAL_OVERCURRENT_FAULT               8
`define IN_SUPPLY_OVP         9
`define IN_THERMAL            10
`define IN_AUTOREC            11
`define IN_PLAIN_COUNT        12

// ----------------------------------------------------------------------------
// Positions in the blanked fault-pin vector
// ----------------------------------------------------------------------------
`define PIN_UPPER             0
`define PIN_LOWER             1
`define PIN_COUNT             2

`endif

// file: verilog/fault_seq_pkg.sv
/*
 * Types shared by the flyback fault sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fault_seq_pkg;

    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_RUN,
        ST_NONLATCH,
        ST_AUTOREC,
        ST_LATCHED,
        ST_DISCHARGE
    } state_t;

endpackage

// file: verilog/input_sync.sv
/*
 * Two-stage synchroniser for a vector of comparator levels, with an optional
 * per-bit blanking filter that passes a high level only after it has stood
 * for longer than BLANK_CYCLES.
 * Assumes a free-running clock; ce_in low freezes all state.
 */
`timescale 1ns/1ps

module input_sync #(
    parameter int unsigned WIDTH        = 1,
    parameter int unsigned BLANK_CYCLES = 0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // ------------------------------------------------------------------------
    // Synchroniser; the first stage feeds only the second
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q   <= '0;
            stable_q <= '0;
        end else if (ce_in) begin
            meta_q   <= level_in;
            stable_q <= meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Blanking filter per bit
    // ------------------------------------------------------------------------
    genvar i;
    generate
        if (BLANK_CYCLES == 0) begin : g_plain
            assign level_out = stable_q;
        end else begin : g_blank
            for (i = 0; i < WIDTH; i++) begin : g_bit
                logic [31:0] cnt_q;
                logic        hit_q;
                // A glitch shorter than the blanking time restarts the count
                always_ff @(posedge clk_in or posedge rst_in) begin
                    if (rst_in) begin
                        cnt_q <= '0;
                        hit_q <= 1'b0;
                    end else if (ce_in) begin
                        if (!stable_q[i]) begin
                            cnt_q <= '0;
                            hit_q <= 1'b0;
                        end else if (cnt_q == BLANK_CYCLES) begin
                            hit_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 32'h1;
                        end
                    end
                end
                assign level_out[i] = hit_q;

                blank_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
                    $rose(hit_q) |-> $past(stable_q[i], 2))
                    else $error("fault pin passed before its blanking delay");
            end
        end
    endgenerate

endmodule

// file: verilog/flyback_fault_sequencer.sv
/*
 * Fault-management sequencer of an offline flyback controller: latching,
 * non-latching and auto-recovery fault modes, brownout timer, line-removal
 * timer and capacitor discharge request.
 * Assumes logic-level comparator results from the analog front end and one
 * free-running 100 MHz clock; all outputs are registered.
 */
// What this block does
// - Three fault responses: latch off, restart when cleared, restart after recovery delay.
// - Latching fault (overcurrent, supply overvoltage, latch pin) drops gate drive immediately.
// - While latched, reaching turn-on does not restart, even with the fault gone.
// - Latch clears only on supply below reset level or line removal.
// - Non-latching fault stops drive; startup source cycles supply between off and on.
// - After fault removal, restart at turn-on if line is above start level.
// - Supply already above turn-on when fault clears: restart at once if line good.
// - Auto-recovery fault stops drive and starts a 1.2 s recovery timer.
// - During recovery timer, startup source holds supply between off and on levels.
// - After recovery timer, start at next turn-on crossing if line is good.
// - Brownout timer starts as soon as line sense drops below stop level.
// - Line below stop for 54 ms declares brownout and disables the controller.
// - Brownout is a non-latching fault until line rises above start level.
// - Line-removal detection runs in every state; only ce_in low freezes it.
// - Line removal is judged from the sampled line-sense slope magnitude.
// - A 100 ms line-removal timer runs while the slope stays below minimum.
// - Sustained upslope for 14 ms or downslope for 1 ms resets that timer.
// - Removal timer expiry requests capacitor discharge and disables the controller.
// - Discharge ends at the discharge end level; then a normal startup begins.
// - Fault-pin detectors count only after staying asserted past 30 us blanking.
`timescale 1ns/1ps

`include "fault_seq_cfg.svh"

module flyback_fault_sequencer #(
    parameter int unsigned AUTOREC_CYCLES   = `AUTOREC_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
    parameter int unsigned BROWNOUT_CYCLES  = `BROWNOUT_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
    parameter int unsigned REMOVAL_CYCLES   = `LINE_REMOVAL_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
    parameter int unsigned UPSLOPE_CYCLES   = `UPSLOPE_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
    parameter int unsigned DOWNSLOPE_CYCLES = `DOWNSLOPE_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    input  wire logic                  supply_turn_on_level_in,
    input  wire logic                  supply_turn_off_level_in,
    input  wire logic                  supply_reset_level_in,
    input  wire logic                  line_start_level_in,
    input  wire logic                  line_stop_level_in,
    input  wire logic                  discharge_end_level_in,
    input  wire logic                  slope_up_in,
    input  wire logic                  slope_down_in,
    input  wire logic                  abnormal_overcurrent_fault_in,
    input  wire logic                  supply_overvoltage_in,
    input  wire logic                  fault_pin_upper_in,
    input  wire logic                  fault_pin_lower_in,
    input  wire logic                  thermal_shutdown_in,
    input  wire logic                  autorec_fault_in,
    output logic                       gate_enable_out,
    output logic                       startup_source_out,
    output logic                       discharge_req_out,
    output logic                       latched_out,
    output logic                       brownout_out,
    output fault_seq_pkg::state_t      state_out
);

    import fault_seq_pkg::*;

    localparam int unsigned BLANK_CYCLES = (`BLANKING_TIME_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    logic [`IN_PLAIN_COUNT-1:0] raw_in;
    logic [`IN_PLAIN_COUNT-1:0] syn;
    logic [`PIN_COUNT-1:0]      pin_raw;
    logic [`PIN_COUNT-1:0]      pin_syn;

    assign raw_in = {autorec_fault_in, thermal_shutdown_in, supply_overvoltage_in,
                     abnormal_overcurrent_fault_in, slope_down_in, slope_up_in,
                     discharge_end_level_in, line_stop_level_in, line_start_level_in,
                     supply_reset_level_in, supply_turn_off_level_in,
                     supply_turn_on_level_in};
    assign pin_raw = {fault_pin_lower_in, fault_pin_upper_in};

    input_sync #(
        .WIDTH        (`IN_PLAIN_COUNT),
        .BLANK_CYCLES (0)
    ) u_plain_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .level_in  (raw_in),
        .level_out (syn)
    );

    input_sync #(
        .WIDTH        (`PIN_COUNT),
        .BLANK_CYCLES (BLANK_CYCLES)
    ) u_pin_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .level_in  (pin_raw),
        .level_out (pin_syn)
    );

    logic vcc_on;
    logic vcc_off;
    logic vcc_reset;
    logic line_ok;
    logic line_low;
    logic disch_end;
    logic latch_fault;
    logic nonlatch_fault;
    logic autorec_fault;

    assign vcc_on      = syn[`IN_SUPPLY_ON];
    assign vcc_off     = syn[`IN_SUPPLY_OFF];
    assign vcc_reset   = syn[`IN_SUPPLY_RESET];
    assign line_ok     = syn[`IN_LINE_START];
    assign line_low    = syn[`IN_LINE_STOP];
    assign disch_end   = syn[`IN_LINE_DISCH_END];
    assign latch_fault = syn[`IN_ABNORMAL_OVERCURRENT_FAULT] | syn[`IN_SUPPLY_OVP] | pin_syn[`PIN_UPPER];
    assign autorec_fault = syn[`IN_AUTOREC];

    // ------------------------------------------------------------------------
    // Brownout timer
    // ------------------------------------------------------------------------
    logic [31:0] bo_cnt_q;
    logic        brownout_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bo_cnt_q   <= '0;
            brownout_q <= 1'b0;
        end else if (ce_in) begin
            if (!line_low) begin
                bo_cnt_q <= '0;
            end else if (bo_cnt_q != BROWNOUT_CYCLES) begin
                bo_cnt_q <= bo_cnt_q + 32'h1;
            end
            // A line between stop and start keeps a declared brownout standing
            if (line_low && bo_cnt_q == BROWNOUT_CYCLES - 1) begin
                brownout_q <= 1'b1;
            end else if (line_ok) begin
                brownout_q <= 1'b0;
            end
        end
    end

    assign nonlatch_fault = brownout_q | syn[`IN_THERMAL] | pin_syn[`PIN_LOWER];

    // ------------------------------------------------------------------------
    // Line-removal detection, free of the state machine
    // ------------------------------------------------------------------------
    logic [31:0] lr_cnt_q;
    logic [31:0] up_cnt_q;
    logic [31:0] dn_cnt_q;
    logic        slope_quiet;
    logic        slope_reset;
    logic        lr_expire;

    assign slope_quiet = !syn[`IN_SLOPE_UP] && !syn[`IN_SLOPE_DOWN];
    assign slope_reset = (up_cnt_q == UPSLOPE_CYCLES) || (dn_cnt_q == DOWNSLOPE_CYCLES);
    assign lr_expire   = slope_quiet && !slope_reset && (lr_cnt_q == REMOVAL_CYCLES - 1);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            up_cnt_q <= '0;
            dn_cnt_q <= '0;
        end else if (ce_in) begin
            if (!syn[`IN_SLOPE_UP]) begin
                up_cnt_q <= '0;
            end else if (up_cnt_q != UPSLOPE_CYCLES) begin
                up_cnt_q <= up_cnt_q + 32'h1;
            end
            if (!syn[`IN_SLOPE_DOWN]) begin
                dn_cnt_q <= '0;
            end else if (dn_cnt_q != DOWNSLOPE_CYCLES) begin
                dn_cnt_q <= dn_cnt_q + 32'h1;
            end
        end
    end

    // Saturating at the limit gives one expiry per quiet spell
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lr_cnt_q <= '0;
        end else if (ce_in) begin
            if (slope_reset) begin
                lr_cnt_q <= '0;
            end else if (slope_quiet && lr_cnt_q != REMOVAL_CYCLES) begin
                lr_cnt_q <= lr_cnt_q + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------
    state_t      state_q;
    state_t      state_d;
    logic [31:0] ar_cnt_q;
    logic        ar_done;
    logic        vcc_on_prev_q;
    logic        vcc_on_rise;
    logic        fault_free;

    assign ar_done     = (ar_cnt_q == AUTOREC_CYCLES);
    assign vcc_on_rise = vcc_on && !vcc_on_prev_q;
    assign fault_free  = !latch_fault && !nonlatch_fault && !autorec_fault;

    always_comb begin
        state_d = state_q;
        if (lr_expire) begin
            state_d = ST_DISCHARGE;
        end else begin
            unique case (state_q)
                ST_DISCHARGE: begin
                    if (disch_end) begin
                        state_d = ST_STARTUP;
                    end
                end
                ST_LATCHED: begin
                    if (vcc_reset) begin
                        state_d = ST_STARTUP;
                    end
                end
                default: begin
                    if (latch_fault) begin
                        state_d = ST_LATCHED;
                    end else if (state_q == ST_AUTOREC) begin
                        if (ar_done && vcc_on_rise && line_ok && fault_free) begin
                            state_d = ST_RUN;
                        end
                    end else if (autorec_fault) begin
                        state_d = ST_AUTOREC;
                    end else if (nonlatch_fault) begin
                        state_d = ST_NONLATCH;
                    end else if (vcc_reset || (state_q == ST_RUN && vcc_off)) begin
                        state_d = ST_STARTUP;
                    end else if (state_q != ST_RUN && vcc_on && line_ok) begin
                        state_d = ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q       <= ST_STARTUP;
            vcc_on_prev_q <= 1'b0;
        end else if (ce_in) begin
            state_q       <= state_d;
            vcc_on_prev_q <= vcc_on;
        end
    end

    // Recovery timer restarts on each entry into the auto-recovery state
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ar_cnt_q <= '0;
        end else if (ce_in) begin
            if (state_q != ST_AUTOREC) begin
                ar_cnt_q <= '0;
            end else if (!ar_done) begin
                ar_cnt_q <= ar_cnt_q + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    logic gate_q;
    logic source_q;
    logic disch_q;
    logic latched_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gate_q <= 1'b0;
        end else if (ce_in) begin
            gate_q <= (state_d == ST_RUN);
        end
    end

    // Hysteretic charging while latched, in recovery and while a non-latching fault stands; startup charges up to turn-on; the source is needed by the
    // discharge path, so it stays off there
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            source_q <= 1'b1;
        end else if (ce_in) begin
            if (state_d == ST_RUN || state_d == ST_DISCHARGE) begin
                source_q <= 1'b0;
            end else if (vcc_on) begin
                source_q <= 1'b0;
            end else if (vcc_off || state_d == ST_STARTUP) begin
                source_q <= 1'b1;
            end else if (state_d == ST_NONLATCH && !nonlatch_fault && line_ok) begin
                source_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            disch_q   <= 1'b0;
            latched_q <= 1'b0;
        end else if (ce_in) begin
            disch_q   <= (state_d == ST_DISCHARGE);
            latched_q <= (state_d == ST_LATCHED);
        end
    end

    assign gate_enable_out    = gate_q;
    assign startup_source_out = source_q;
    assign discharge_req_out  = disch_q;
    assign latched_out        = latched_q;
    assign brownout_out       = brownout_q;
    assign state_out          = state_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // A supply reset while latched clears the latch for one cycle even if the fault stands
    sequence s_latch_seen;
        ce_in && latch_fault && !lr_expire && state_q != ST_DISCHARGE && !(state_q == ST_LATCHED && vcc_reset);
    endsequence

    sequence s_quiet_full;
        ce_in && lr_expire;
    endsequence

    latch_gate_off_a: assert property (s_latch_seen |=> !gate_q && state_q == ST_LATCHED)
        else $error("latching fault left gate drive on");
    latch_holds_a: assert property (ce_in && state_q == ST_LATCHED && !vcc_reset && !lr_expire
                                    |=> state_q == ST_LATCHED && !gate_q)
        else $error("latched state left without reset or removal");
    latch_clear_a: assert property (ce_in && state_q == ST_LATCHED && vcc_reset && !lr_expire
                                    |=> state_q == ST_STARTUP)
        else $error("supply reset did not clear the latch");
    latch_priority_a: assert property (s_latch_seen and (autorec_fault || nonlatch_fault)
                                       |=> state_q == ST_LATCHED)
        else $error("lesser fault outranked a latching fault");
    brownout_set_a: assert property (ce_in && line_low && bo_cnt_q == BROWNOUT_CYCLES - 1
                                     |=> brownout_q)
        else $error("brownout not declared at timer expiry");
    removal_disch_a: assert property (s_quiet_full |=> disch_q && !gate_q && !source_q
                                      ##0 state_q == ST_DISCHARGE)
        else $error("line removal did not start discharge");
    disch_end_a: assert property (ce_in && state_q == ST_DISCHARGE && disch_end && !lr_expire
                                  |=> state_q == ST_STARTUP && !disch_q)
        else $error("discharge did not hand over to startup");
    autorec_wait_a: assert property (ce_in && state_q == ST_AUTOREC && !ar_done
                                     |=> !gate_q)
        else $error("switching resumed before recovery timer ran out");
    nonlatch_charge_a: assert property (ce_in && state_q == ST_NONLATCH && nonlatch_fault
                                        && !latch_fault && !autorec_fault && !lr_expire
                                        && vcc_off && !vcc_on |=> source_q && !gate_q)
        else $error("startup source off below turn-off level during fault");

endmodule

// file: bench/supply_model.sv
/*
 * Behavioural model of the supply rail and its three comparators.
 * Assumes the sequencer's gate and startup outputs; drain_in pulls the rail down.
 */
`timescale 1ns/1ps

module supply_model (
    input  wire logic clk_in,
    input  wire logic gate_in,
    input  wire logic source_in,
    input  wire logic drain_in,
    output logic      on_out,
    output logic      off_out,
    output logic      reset_out
);
    // ------------------------------------------------------------------
    // Rail
    // ------------------------------------------------------------------
    int vcc = 0;
    // Aux winding holds the rail while switching; bias current drains it
    always @(posedge clk_in) begin
        if (drain_in) vcc <= (vcc > 1) ? vcc - 2 : 0;
        else if (source_in) vcc <= vcc + 1;
        else if (!gate_in && vcc > 0) vcc <= vcc - 1;
    end
    assign on_out    = (vcc >= 80);
    assign off_out   = (vcc <= 40);
    assign reset_out = (vcc <= 10);
endmodule

// file: bench/flyback_fault_sequencer_test.sv
/*
 * Self-checking bench for the flyback fault sequencer.
 * Assumes shortened timer parameters and the supply_model partner.
 */
`timescale 1ns/1ps

module flyback_fault_sequencer_test;
    import fault_seq_pkg::*;
    localparam int AR = 200;
    localparam int BO = 50;
    localparam int RM = 100;
    localparam int BLANK = 3000;   // 30 us at 100 MHz
    logic   clk_in = 0, rst_in = 1, ce = 1, drain = 0, line_start = 0, line_stop = 0;
    logic   disch_end = 0, s_up = 0, s_dn = 1, abnormal_overcurrent_fault = 0, ovp = 0, pin_up = 0;
    logic   pin_lo = 0, therm = 0, arf = 0, v_on, v_off, v_rst, gate, src, dreq, latched, bo;
    state_t st;
    int     n_mismatch = 0, checked = 0, cyc = 0, n;

    // ------------------------------------------------------------------
    // Device and partner
    // ------------------------------------------------------------------
    flyback_fault_sequencer #(.AUTOREC_CYCLES(AR), .BROWNOUT_CYCLES(BO), .REMOVAL_CYCLES(RM),
        .UPSLOPE_CYCLES(20), .DOWNSLOPE_CYCLES(5)) flyback_fault_sequencer_i (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .supply_turn_on_level_in(v_on),
        .supply_turn_off_level_in(v_off), .supply_reset_level_in(v_rst),
        .line_start_level_in(line_start), .line_stop_level_in(line_stop),
        .discharge_end_level_in(disch_end), .slope_up_in(s_up), .slope_down_in(s_dn),
        .abnormal_overcurrent_fault_in(abnormal_overcurrent_fault), .supply_overvoltage_in(ovp),
        .fault_pin_upper_in(pin_up), .fault_pin_lower_in(pin_lo), .thermal_shutdown_in(therm),
        .autorec_fault_in(arf), .gate_enable_out(gate), .startup_source_out(src),
        .discharge_req_out(dreq), .latched_out(latched), .brownout_out(bo), .state_out(st));
    supply_model supply_model_i (.clk_in(clk_in), .gate_in(gate), .source_in(src),
        .drain_in(drain), .on_out(v_on), .off_out(v_off), .reset_out(v_rst));

    initial forever #5 clk_in = ~clk_in;

    // Ceiling is several times the expected run length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task check(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task wait_st(input state_t s, input int lim);
        n = 0;
        while (st !== s && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_freeze;
        ce = 0;
        abnormal_overcurrent_fault = 1;
        tick(20);
        check(st === ST_RUN && gate === 1'b1 && latched === 1'b0, "state moved while frozen");
        abnormal_overcurrent_fault = 0;
        tick(1);
        ce = 1;
        tick(5);
        check(st === ST_RUN && gate === 1'b1, "frozen fault leaked through");
        $display("test freeze done");
    endtask
    task t_latch;
        tick(1);
        abnormal_overcurrent_fault = 1;
        therm = 1;
        tick(2);
        check(gate === 1'b1, "gate dropped before sync");
        tick(1);
        check(gate === 1'b0 && latched === 1'b1, "latch entry");
        abnormal_overcurrent_fault = 0;
        therm = 0;
        tick(300);
        check(latched === 1'b1 && gate === 1'b0, "restarted while latched");
        drain = 1;
        wait_st(ST_STARTUP, 200);
        check(st === ST_STARTUP && src === 1'b1, "latch not cleared");
        drain = 0;
        wait_st(ST_RUN, 300);
        check(gate === 1'b1, "no restart after clear");
        $display("test latch done");
    endtask
    task t_brownout;
        line_stop = 1;
        line_start = 0;
        n = 0;
        while (bo !== 1'b1 && n < BO + 20) begin
            tick(1);
            n++;
        end
        check(n >= BO && n <= BO + 4, "brownout delay");
        tick(1);
        check(st === ST_NONLATCH && gate === 1'b0, "brownout entry");
        tick(200);
        check(st === ST_NONLATCH && gate === 1'b0, "brownout left early");
        line_stop = 0;
        line_start = 1;
        wait_st(ST_RUN, 300);
        check(gate === 1'b1 && bo === 1'b0, "brownout recovery");
        $display("test brownout done");
    endtask
    task t_autorec;
        arf = 1;
        tick(3);
        check(st === ST_AUTOREC && gate === 1'b0, "auto-recovery entry");
        arf = 0;
        wait_st(ST_RUN, 2 * AR + 300);
        check(st === ST_RUN && n >= AR - 3, "auto-recovery delay");
        $display("test autorec done");
    endtask
    task t_removal;
        s_dn = 0;
        wait_st(ST_DISCHARGE, RM + 50);
        check(dreq === 1'b1 && gate === 1'b0 && n >= RM - 5, "line removal");
        disch_end = 1;
        wait_st(ST_STARTUP, 20);
        // Rail is still above turn-on, so the startup source stays off
        check(dreq === 1'b0 && st === ST_STARTUP && v_on === 1'b1 && src === 1'b0, "discharge end");
        disch_end = 0;
        s_dn = 1;
        tick(1);
        check(st === ST_RUN && gate === 1'b1, "no fresh start after discharge");
        $display("test removal done");
    endtask
    task t_pin;
        pin_up = 1;
        tick(BLANK - 500);
        pin_up = 0;
        tick(5);
        check(latched === 1'b0 && gate === 1'b1, "short fault pin pulse latched");
        pin_up = 1;
        wait_st(ST_LATCHED, BLANK + 50);
        check(latched === 1'b1 && gate === 1'b0 && n > BLANK, "fault pin blanking");
        pin_up = 0;
        $display("test pin done");
    endtask

    initial begin
        tick(11);
        check(gate === 1'b0 && src === 1'b1 && st === ST_STARTUP, "reset values");
        tick(1);
        rst_in = 0;
        line_start = 1;
        wait_st(ST_RUN, 300);
        check(gate === 1'b1 && src === 1'b0, "power-on start");
        t_freeze();
        t_latch();
        t_brownout();
        t_autorec();
        t_removal();
        t_pin();
        print_verdict();
    end
endmodule
